// *** si_pkg.sv ***
package si_pkg;

    // bus geometry
    localparam int          ADDR_W        = 8;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

    // register map
    localparam logic [ADDR_W-1:0] CTRL_STATUS_OFFSET = 8'h00;
    localparam logic [7:0]  CTRL_STATUS_RESET = 8'h00;
    localparam int          WDG_FLAG_BIT  = 0;
    localparam int          LVD_FLAG_BIT  = 4;
    localparam int          AUX_FLAG_BIT  = 5;
    localparam int          AUX_EN_BIT    = 6;

    // timing
    localparam int          CNT_W         = 13;
    localparam int          CLK_PERIOD_NS = 5;
    localparam int          DELAY_SHORT_CYC = 256;
    localparam int          DELAY_LONG_CYC  = 4096;
    localparam int          WDG_PULSE_NS  = 200;
    localparam int          WDG_PULSE_CYC =
        (WDG_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          PIN_SETTLE_CYC = 4;

    // reset sequencer phases
    typedef enum logic [1:0] {
        SEQ_RUN    = 2'b00,
        SEQ_ACTIVE = 2'b01,
        SEQ_DELAY  = 2'b10
    } seq_state_e;

    // axi4-lite master to slave
    typedef struct packed {
        logic              awvalid;
        logic [ADDR_W-1:0] awaddr;
        logic              wvalid;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              bready;
        logic              arvalid;
        logic [ADDR_W-1:0] araddr;
        logic              rready;
    } axil_req_s;

    // axi4-lite slave to master
    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } axil_rsp_s;

endpackage : si_pkg

// *** si_sync3.sv ***
`timescale 1ns/100ps
`default_nettype none

module si_sync3 #(
    parameter logic RESET_LEVEL = 1'b0
) (
    // clock and reset
    input  wire logic clock,
    input  wire logic reset,
    // asynchronous level in, filtered level out
    input  wire logic async_in,
    output var  logic level_q
);

    logic s1_q;
    logic s2_q;
    logic s3_q;

    // three stages, change taken when stages two and three agree
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            s1_q    <= RESET_LEVEL;
            s2_q    <= RESET_LEVEL;
            s3_q    <= RESET_LEVEL;
            level_q <= RESET_LEVEL;
        end else begin
            s1_q <= async_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                level_q <= s3_q;
            end
        end
    end

endmodule : si_sync3

`default_nettype wire

// *** si_timer.sv ***
`timescale 1ns/100ps
`default_nettype none

module si_timer #(
    parameter int W = 13
) (
    // clock and reset
    input  wire logic         clock,
    input  wire logic         reset,
    // load and status
    input  wire logic         load,
    input  wire logic [W-1:0] load_val,
    output logic              zero,
    output logic [W-1:0]      left
);

    logic [W-1:0] count_q;

    // down counter, stops at zero
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            count_q <= '0;
        end else if (load) begin
            count_q <= load_val;
        end else if (count_q != '0) begin
            count_q <= count_q - W'(1);
        end
    end

    assign zero = (count_q == '0);
    assign left = count_q;

endmodule : si_timer

`default_nettype wire

// *** system_integrity_reset_flags.sv ***
// Contract
// - hold reset pin low during low-voltage reset
// - watchdog underflow drives pin low minimum time
// - bit 5 live aux comparator copy, read-only
// - bit 6 enables toggle interrupt, cleared on entry
// - aux detection works only with detector enabled
// - no aux interrupt during reset delay; a write setting bit 6 while the aux flag is set still raises one in any phase
// - enable below threshold gives immediate interrupt
// - enable above threshold gives no immediate interrupt
// - aux interrupt wakes processor from wait
// - halt freezes register, no wake from halt
// - interrupt needs enable and cleared cpu mask
// - bit 4 set by low-voltage reset, write-zero clears
// - low-voltage flag survives pin, watchdog resets
// - low-voltage flag meaningless without detector
// - bit 0 watchdog flag, cleared by write, lvd
// - two flags encode last reset cause
// - bits 7 and 3:1 read zero
// - enable resets zero, flags keep history
// - internal reset held 256 or 4096 cycles
//
// The AXI4-Lite register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

module system_integrity_reset_flags #(
    parameter int DELAY_SHORT = si_pkg::DELAY_SHORT_CYC,
    parameter int DELAY_LONG  = si_pkg::DELAY_LONG_CYC,
    parameter int WDG_PULSE   = si_pkg::WDG_PULSE_CYC
) (
    // clock and reset
    input  wire logic              clock,
    input  wire logic              reset,
    // register bus
    input  wire si_pkg::axil_req_s axil_req,
    output si_pkg::axil_rsp_s      axil_rsp,
    // option configuration
    input  wire logic              opt_lvd_enable,
    input  wire logic              opt_long_delay,
    // analog detector and watchdog events
    input  wire logic              lvd_below,
    input  wire logic              aux_below,
    input  wire logic              watchdog_underflow,
    // open-drain reset pin
    input  wire logic              rst_pin_i,
    output logic                   rst_pin_o,
    output logic                   rst_pin_oe,
    // processor side
    input  wire logic              cpu_irq_mask,
    input  wire logic              cpu_irq_ack,
    input  wire logic              cpu_wait,
    input  wire logic              cpu_halt,
    output logic                   internal_reset,
    output logic                   aux_irq,
    output logic                   wake_from_wait
);

    localparam int CW = si_pkg::CNT_W;

    typedef struct packed {
        si_pkg::seq_state_e        seq;
        logic                      src_lvd;
        logic                      src_wdg;
        logic                      aux_flag;
        logic                      aux_en;
        logic                      pend;
        logic                      lvd_rf;
        logic                      wdg_rf;
        logic                      irq;
        logic                      wake;
        logic                      pin_oe;
        logic                      int_rst;
        logic                      aw_have;
        logic [si_pkg::ADDR_W-1:0] aw_addr;
        logic                      w_have;
        logic [7:0]                w_data;
        logic                      w_strb0;
        logic                      awready;
        logic                      wready;
        logic                      bvalid;
        logic [1:0]                bresp;
        logic                      arready;
        logic                      rvalid;
        logic [7:0]                rdata;
        logic [1:0]                rresp;
    } state_s;

    state_s         s_q;
    state_s         s_d;
    logic           lvd_lvl;
    logic           aux_lvl;
    logic           pin_lvl;
    logic           t_load;
    logic [CW-1:0]  t_val;
    logic           t_zero;
    logic [CW-1:0]  t_left;

    // register image, reserved bits zero
    function automatic logic [7:0] reg_image(input state_s s);
        logic [7:0] v;
        v = si_pkg::CTRL_STATUS_RESET;
        v[si_pkg::AUX_EN_BIT]   = s.aux_en;
        v[si_pkg::AUX_FLAG_BIT] = s.aux_flag;
        v[si_pkg::LVD_FLAG_BIT] = s.lvd_rf;
        v[si_pkg::WDG_FLAG_BIT] = s.wdg_rf;
        return v;
    endfunction : reg_image

    // only one register word is mapped
    function automatic logic hit(input logic [si_pkg::ADDR_W-1:0] a);
        return a[si_pkg::ADDR_W-1:2] ==
               si_pkg::CTRL_STATUS_OFFSET[si_pkg::ADDR_W-1:2];
    endfunction : hit

    // synchronisers for analog and pin levels
    si_sync3 #(.RESET_LEVEL(1'b0)) u_sync_lvd (
        .clock    (clock),
        .reset    (reset),
        .async_in (lvd_below),
        .level_q  (lvd_lvl)
    );

    si_sync3 #(.RESET_LEVEL(1'b0)) u_sync_aux (
        .clock    (clock),
        .reset    (reset),
        .async_in (aux_below),
        .level_q  (aux_lvl)
    );

    si_sync3 #(.RESET_LEVEL(1'b1)) u_sync_pin (
        .clock    (clock),
        .reset    (reset),
        .async_in (rst_pin_i),
        .level_q  (pin_lvl)
    );

    // shared pulse and delay counter
    si_timer #(.W(CW)) u_timer (
        .clock    (clock),
        .reset    (reset),
        .load     (t_load),
        .load_val (t_val),
        .zero     (t_zero),
        .left     (t_left)
    );

    // next-state logic
    always_comb begin
        logic lvd_req;
        logic act_done;
        logic enter_rst;
        logic do_wr;
        logic [si_pkg::ADDR_W-1:0] wa;
        logic [7:0] wd;
        logic ws;
        logic aux_now;
        s_d       = s_q;
        t_load    = 1'b0;
        t_val     = '0;
        lvd_req   = lvd_lvl & opt_lvd_enable;
        act_done  = 1'b0;
        enter_rst = 1'b0;
        do_wr     = 1'b0;
        wa        = s_q.aw_addr;
        wd        = s_q.w_data;
        ws        = s_q.w_strb0;
        aux_now   = 1'b0;

        // reset sequencer
        case (s_q.seq)
            si_pkg::SEQ_RUN: begin
                if (watchdog_underflow && !lvd_req) begin
                    s_d.seq     = si_pkg::SEQ_ACTIVE;
                    s_d.src_lvd = 1'b0;
                    s_d.src_wdg = 1'b1;
                    t_load      = 1'b1;
                    t_val       = CW'(WDG_PULSE);
                    enter_rst   = 1'b1;
                end else if (!pin_lvl && !lvd_req) begin
                    s_d.seq     = si_pkg::SEQ_ACTIVE;
                    s_d.src_lvd = 1'b0;
                    s_d.src_wdg = 1'b0;
                    enter_rst   = 1'b1;
                end
            end
            si_pkg::SEQ_ACTIVE: begin
                if (s_q.src_lvd) begin
                    act_done = !lvd_req;
                end else if (s_q.src_wdg) begin
                    act_done = t_zero;
                end else begin
                    act_done = pin_lvl;
                end
                if (act_done) begin
                    s_d.seq = si_pkg::SEQ_DELAY;
                    t_load  = 1'b1;
                    t_val   = opt_long_delay ? CW'(DELAY_LONG)
                                             : CW'(DELAY_SHORT);
                end
            end
            si_pkg::SEQ_DELAY: begin
                if (t_zero) begin
                    s_d.seq = si_pkg::SEQ_RUN;
                end
            end
            default: begin
                s_d.seq = si_pkg::SEQ_RUN;
            end
        endcase

        // low-voltage reset overrides every phase
        if (lvd_req) begin
            enter_rst   = s_q.seq != si_pkg::SEQ_ACTIVE || !s_q.src_lvd;
            s_d.seq     = si_pkg::SEQ_ACTIVE;
            s_d.src_lvd = 1'b1;
            s_d.src_wdg = 1'b0;
        end

        // interrupt acknowledge on handler entry
        if (cpu_irq_ack) begin
            s_d.pend = 1'b0;
        end

        // write address and data channels, either order
        if (axil_req.awvalid && s_q.awready) begin
            s_d.aw_have = 1'b1;
            s_d.aw_addr = axil_req.awaddr;
            wa          = axil_req.awaddr;
        end
        if (axil_req.wvalid && s_q.wready) begin
            s_d.w_have  = 1'b1;
            s_d.w_data  = axil_req.wdata[7:0];
            s_d.w_strb0 = axil_req.wstrb[0];
            wd          = axil_req.wdata[7:0];
            ws          = axil_req.wstrb[0];
        end
        if (s_q.bvalid && axil_req.bready) begin
            s_d.bvalid = 1'b0;
        end
        if (s_d.aw_have && s_d.w_have && !s_q.bvalid) begin
            s_d.aw_have = 1'b0;
            s_d.w_have  = 1'b0;
            s_d.bvalid  = 1'b1;
            s_d.bresp   = hit(wa) ? si_pkg::RESP_OKAY
                                  : si_pkg::RESP_SLVERR;
            do_wr       = hit(wa) && ws && !cpu_halt;
        end

        // register write: flags only clear, enable stores
        if (do_wr) begin
            s_d.aux_en = wd[si_pkg::AUX_EN_BIT];
            if (!wd[si_pkg::LVD_FLAG_BIT]) begin
                s_d.lvd_rf = 1'b0;
            end
            if (!wd[si_pkg::WDG_FLAG_BIT]) begin
                s_d.wdg_rf = 1'b0;
            end
            if (wd[si_pkg::AUX_EN_BIT] && !s_q.aux_en &&
                s_q.aux_flag) begin
                s_d.pend = 1'b1;
            end
        end

        // read channel
        if (s_q.rvalid && axil_req.rready) begin
            s_d.rvalid = 1'b0;
        end
        if (axil_req.arvalid && s_q.arready) begin
            s_d.rvalid = 1'b1;
            s_d.rdata  = hit(axil_req.araddr) ? reg_image(s_q) : 8'h00;
            s_d.rresp  = hit(axil_req.araddr) ? si_pkg::RESP_OKAY
                                              : si_pkg::RESP_SLVERR;
        end

        // aux comparator tracking and toggle detection
        if (!cpu_halt) begin
            aux_now      = aux_lvl & opt_lvd_enable;
            s_d.aux_flag = aux_now;
            if (aux_now != s_q.aux_flag && s_q.aux_en &&
                s_q.seq == si_pkg::SEQ_RUN) begin
                s_d.pend = 1'b1;
            end
        end

        // a new reset clears the enable and pending state
        if (enter_rst) begin
            s_d.aux_en = 1'b0;
            s_d.pend   = 1'b0;
        end

        // reset cause flags, hardware set wins over write
        if (lvd_req) begin
            s_d.lvd_rf = 1'b1;
            s_d.wdg_rf = 1'b0;
        end else if (enter_rst && s_d.src_wdg) begin
            s_d.wdg_rf = 1'b1;
        end

        if (!opt_lvd_enable) begin
            s_d.pend = 1'b0;
        end

        // interrupt and wake lines
        s_d.irq  = s_d.pend && s_d.aux_en && !cpu_irq_mask;
        s_d.wake = s_d.pend && s_d.aux_en && cpu_wait &&
                   !cpu_halt;

        // pin drive: own sources while active, any source in delay, released before the end
        s_d.pin_oe = (s_d.seq == si_pkg::SEQ_ACTIVE &&
                      (s_d.src_lvd || s_d.src_wdg)) ||
                     (s_d.seq == si_pkg::SEQ_DELAY &&
                      (t_load || t_left > CW'(si_pkg::PIN_SETTLE_CYC)));
        s_d.int_rst = s_d.seq != si_pkg::SEQ_RUN;

        // bus readiness
        s_d.awready = !s_d.aw_have && !s_d.bvalid;
        s_d.wready  = !s_d.w_have && !s_d.bvalid;
        s_d.arready = !s_d.rvalid;
    end

    // state register, power-up reset starts in run phase, internal reset held until the first edge
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            s_q         <= '0;
            s_q.seq     <= si_pkg::SEQ_RUN;
            s_q.int_rst <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from the state register, pin data tied low
    assign axil_rsp.awready = s_q.awready;
    assign axil_rsp.wready  = s_q.wready;
    assign axil_rsp.bvalid  = s_q.bvalid;
    assign axil_rsp.bresp   = s_q.bresp;
    assign axil_rsp.arready = s_q.arready;
    assign axil_rsp.rvalid  = s_q.rvalid;
    assign axil_rsp.rdata   = {24'h000000, s_q.rdata};
    assign axil_rsp.rresp   = s_q.rresp;
    assign rst_pin_o        = 1'b0;                 // open drain low
    assign rst_pin_oe       = s_q.pin_oe;
    assign internal_reset   = s_q.int_rst;
    assign aux_irq          = s_q.irq;
    assign wake_from_wait   = s_q.wake;

endmodule : system_integrity_reset_flags

`default_nettype wire

// *** system_integrity_reset_flags_assertions.sv ***
`timescale 1ns/100ps
`default_nettype none

module si_flags_checker (
    // clock and reset
    input wire logic              clock,
    input wire logic              reset,
    // watched ports
    input wire si_pkg::axil_rsp_s axil_rsp,
    input wire logic              opt_lvd_enable,
    input wire logic              lvd_below,
    input wire logic              watchdog_underflow,
    input wire logic              rst_pin_oe,
    input wire logic              cpu_irq_mask,
    input wire logic              cpu_wait,
    input wire logic              cpu_halt,
    input wire logic              internal_reset,
    input wire logic              aux_irq,
    input wire logic              wake_from_wait
);
    default clocking @(posedge clock);
    endclocking
    default disable iff (reset);

    // reset source steps
    sequence wdg_start;
        watchdog_underflow && !internal_reset;
    endsequence
    sequence lvd_low;
        (opt_lvd_enable && lvd_below)[*8];
    endsequence

    // pin and sequencer relations
    AST_WDG_PIN: assert property (wdg_start |=> rst_pin_oe && internal_reset)
        else $error("watchdog start did not drive pin");
    AST_WDG_HOLD: assert property (wdg_start |=> rst_pin_oe[*4])
        else $error("watchdog pin pulse too short");
    AST_LVD_PIN: assert property (lvd_low |-> rst_pin_oe && internal_reset)
        else $error("pin released during low supply");
    AST_PIN_IDLE: assert property (!internal_reset |-> !rst_pin_oe)
        else $error("pin driven outside reset sequence");
    // interrupt relations
    AST_IRQ_MASK: assert property (aux_irq |-> !$past(cpu_irq_mask))
        else $error("interrupt raised while masked");
    AST_IRQ_SEQ: assert property (internal_reset[*2] |-> !aux_irq)
        else $error("interrupt during reset sequence");
    AST_WAKE: assert property (wake_from_wait |-> $past(cpu_wait) && !$past(cpu_halt))
        else $error("wake outside wait or in halt");
    // register read layout
    AST_RSVD: assert property (axil_rsp.rvalid |-> axil_rsp.rdata[31:7] == 25'h0 && axil_rsp.rdata[3:1] == 3'h0)
        else $error("reserved bits read nonzero");
endmodule : si_flags_checker

bind system_integrity_reset_flags si_flags_checker i_si_flags_checker (
    .clock(clock), .reset(reset), .axil_rsp(axil_rsp),
    .opt_lvd_enable(opt_lvd_enable), .lvd_below(lvd_below),
    .watchdog_underflow(watchdog_underflow), .rst_pin_oe(rst_pin_oe),
    .cpu_irq_mask(cpu_irq_mask), .cpu_wait(cpu_wait), .cpu_halt(cpu_halt),
    .internal_reset(internal_reset), .aux_irq(aux_irq),
    .wake_from_wait(wake_from_wait)
);

`default_nettype wire

// *** system_integrity_reset_flags_tb.sv ***
`timescale 1ns/100ps
`default_nettype none

module system_integrity_reset_flags_tb;
    localparam logic [1:0] OK  = si_pkg::RESP_OKAY;
    localparam logic [1:0] ERR = si_pkg::RESP_SLVERR;
    logic clock, reset, opt_lvd_enable, opt_long_delay, lvd_below, aux_below;
    logic watchdog_underflow, rst_pin_i, rst_pin_oe, cpu_irq_mask, cpu_irq_ack;
    logic cpu_wait, cpu_halt, internal_reset, aux_irq, wake_from_wait;
    logic ext_rst_n, rst_pin_o;
    si_pkg::axil_req_s req;
    si_pkg::axil_rsp_s rsp;
    int n_mismatch = 0;
    int tests_run  = 0;
    int cycles     = 0;

    // shortened counts keep the run brief
    system_integrity_reset_flags #(.DELAY_SHORT(8), .DELAY_LONG(16),
        .WDG_PULSE(6)) i_system_integrity_reset_flags (
        .clock(clock), .reset(reset), .axil_req(req), .axil_rsp(rsp),
        .opt_lvd_enable(opt_lvd_enable), .opt_long_delay(opt_long_delay),
        .lvd_below(lvd_below), .aux_below(aux_below),
        .watchdog_underflow(watchdog_underflow), .rst_pin_i(rst_pin_i),
        .rst_pin_o(rst_pin_o), .rst_pin_oe(rst_pin_oe),
        .cpu_irq_mask(cpu_irq_mask),
        .cpu_irq_ack(cpu_irq_ack), .cpu_wait(cpu_wait), .cpu_halt(cpu_halt),
        .internal_reset(internal_reset), .aux_irq(aux_irq),
        .wake_from_wait(wake_from_wait));

    // open-drain reset pin with pull-up, low while either side drives it
    assign rst_pin_i = ext_rst_n && (rst_pin_oe ? rst_pin_o : 1'b1);

    // clock and hang guard
    always #2.5 clock = ~clock;
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_mismatch++;
            report_and_stop();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask : tick

    // bus write, ready sampled at the negedge before the edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d,
                      input logic [1:0] er);
        logic aw, w, b;
        logic [1:0] gr;
        int n;
        @(posedge clock);
        req.awaddr  <= a;
        req.awvalid <= 1'b1;
        req.wdata   <= {24'h0, d};
        req.wstrb   <= 4'hf;
        req.wvalid  <= 1'b1;
        req.bready  <= 1'b1;
        b = 1'b0;
        n = 0;
        while (!b && n < 50) begin
            @(negedge clock);
            aw = req.awvalid && rsp.awready;
            w  = req.wvalid && rsp.wready;
            b  = rsp.bvalid && req.bready;
            gr = rsp.bresp;
            @(posedge clock);
            if (aw) req.awvalid <= 1'b0;
            if (w) req.wvalid <= 1'b0;
            n++;
        end
        req.bready <= 1'b0;
        chk(b, 1'b1);
        chk(gr, er);
    endtask : wr

    // bus read, compares the whole word (upper bytes zero) and response
    task automatic rd(input logic [7:0] a, input logic [7:0] e,
                      input logic [1:0] er);
        logic ar, hit;
        logic [31:0] got;
        logic [1:0] gr;
        int n;
        @(posedge clock);
        req.araddr  <= a;
        req.arvalid <= 1'b1;
        req.rready  <= 1'b1;
        hit = 1'b0;
        n = 0;
        while (!hit && n < 50) begin
            @(negedge clock);
            ar  = req.arvalid && rsp.arready;
            hit = rsp.rvalid && req.rready;
            got = rsp.rdata;
            gr  = rsp.rresp;
            @(posedge clock);
            if (ar) req.arvalid <= 1'b0;
            n++;
        end
        req.rready <= 1'b0;
        chk(hit, 1'b1);
        chk(got, {24'h0, e});
        chk(gr, er);
    endtask : rd

    task automatic wait_irq(input logic e);
        int n;
        n = 0;
        @(negedge clock);
        while (aux_irq !== e && n < 12) begin
            @(negedge clock);
            n++;
        end
        chk(aux_irq, e);
        @(posedge clock);
    endtask : wait_irq

    task automatic wait_idle(output int n);
        n = 0;
        @(negedge clock);
        while (internal_reset === 1'b1 && n < 200) begin
            @(negedge clock);
            n++;
        end
        chk(internal_reset, 1'b0);
        @(posedge clock);
    endtask : wait_idle

    task automatic pulse_wdg;
        watchdog_underflow <= 1'b1;
        @(posedge clock);
        watchdog_underflow <= 1'b0;
    endtask : pulse_wdg

    task automatic pulse_ack;
        cpu_irq_ack <= 1'b1;
        @(posedge clock);
        cpu_irq_ack <= 1'b0;
    endtask : pulse_ack

    task automatic t_regs;
        rd(8'h00, 8'h00, OK);
        rd(8'h04, 8'h00, ERR);
        wr(8'h08, 8'hff, ERR);
        rd(8'h00, 8'h00, OK);
    endtask : t_regs

    task automatic t_wdg(input logic lng);
        int n, dly;
        dly = lng ? 16 : 8;
        opt_long_delay <= lng;
        @(posedge clock);
        pulse_wdg();
        @(negedge clock);
        chk(rst_pin_oe, 1'b1);
        chk(rst_pin_o, 1'b0);
        wait_idle(n);
        chk(n >= dly + 4 && n <= dly + 16, 1'b1);
        rd(8'h00, 8'h01, OK);
        wr(8'h00, 8'hff, OK);
        rd(8'h00, 8'h41, OK);
        wr(8'h00, 8'h00, OK);
        rd(8'h00, 8'h00, OK);
    endtask : t_wdg

    task automatic t_lvd;
        int n;
        pulse_wdg();
        wait_idle(n);
        lvd_below <= 1'b1;
        tick(20);
        @(negedge clock);
        chk(rst_pin_oe, 1'b1);
        @(posedge clock);
        lvd_below <= 1'b0;
        wait_idle(n);
        rd(8'h00, 8'h10, OK);
        pulse_wdg();
        wait_idle(n);
        rd(8'h00, 8'h11, OK);
        wr(8'h00, 8'h00, OK);
        rd(8'h00, 8'h00, OK);
    endtask : t_lvd

    // external pin reset: block does not drive the pin while it is held, flags stay clear
    task automatic t_pin;
        int n;
        ext_rst_n <= 1'b0;
        tick(10);
        @(negedge clock);
        chk(internal_reset, 1'b1);
        chk(rst_pin_oe, 1'b0);
        @(posedge clock);
        ext_rst_n <= 1'b1;
        wait_idle(n);
        rd(8'h00, 8'h00, OK);
    endtask : t_pin

    task automatic t_aux;
        wr(8'h00, 8'h40, OK);
        tick(12);
        wait_irq(1'b0);
        aux_below <= 1'b1;
        wait_irq(1'b1);
        pulse_ack();
        wait_irq(1'b0);
        rd(8'h00, 8'h60, OK);
        wr(8'h00, 8'h00, OK);
        wr(8'h00, 8'h40, OK);
        wait_irq(1'b1);
        pulse_ack();
        cpu_irq_mask <= 1'b1;
        aux_below    <= 1'b0;
        tick(12);
        wait_irq(1'b0);
        cpu_wait <= 1'b1;
        tick(3);
        @(negedge clock);
        chk(wake_from_wait, 1'b1);
        @(posedge clock);
        cpu_irq_mask <= 1'b0;
        wait_irq(1'b1);
        pulse_ack();
        cpu_wait <= 1'b0;
        cpu_halt <= 1'b1;
        wr(8'h00, 8'h00, OK);
        aux_below <= 1'b1;
        tick(12);
        rd(8'h00, 8'h40, OK);
        wait_irq(1'b0);
        cpu_halt <= 1'b0;
        tick(12);
        pulse_ack();
        opt_lvd_enable <= 1'b0;
        aux_below      <= 1'b0;
        tick(12);
        wait_irq(1'b0);
        rd(8'h00, 8'h40, OK);
        wr(8'h00, 8'h00, OK);
        opt_lvd_enable <= 1'b1;
    endtask : t_aux

    task automatic report_and_stop;
        if (n_mismatch == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : report_and_stop

    // reset, then the scenarios in turn
    initial begin
        clock = 1'b0;
        reset = 1'b1;
        req = '0;
        {opt_lvd_enable, ext_rst_n} = 2'h3;
        {opt_long_delay, lvd_below, aux_below, watchdog_underflow} = 4'h0;
        {cpu_irq_mask, cpu_irq_ack, cpu_wait, cpu_halt} = 4'h0;
        tick(3);
        reset <= 1'b0;
        tick(8);
        t_regs();
        t_wdg(1'b0);
        t_wdg(1'b1);
        t_lvd();
        t_pin();
        t_aux();
        report_and_stop();
    end
endmodule : system_integrity_reset_flags_tb

`default_nettype wire
